//--- lpc_ctrl.sv
/*
 * lpc_ctrl: control logic around a single-wire bus transceiver: enable and ready delay,
 * slope selection, overheat shutdown, undervoltage blocking, wake-up detection, routing.
 * assumes all analog condition inputs are synchronous to clk_i and a classic Wishbone master.
 */
`timescale 1ns/1ps
// What this block does
// [R01] slope select resets to normal 20 kbit mode
// [R02] three slope modes offered: 10, 20 and fast 100 kbit
// [R03] slope code 00 normal, 01 slow, 10 fast, 11 normal
// [R04] overheat disables transmitter; overheat indication follows the condition
// [R05] overheat with irq enable set raises the interrupt request
// [R06] writing one to the overheat flag clears it
// [R07] new overheat interrupt only after the condition vanished and came back
// [R08] transmitter re-enabled after overheat clears and transmit input is high
// [R09] low power keeps transmitter off, receiver stays active
// [R10] long dominant then rising edge in low power records a wake-up
// [R11] low-voltage shutdown with undervoltage blocks further dominant drive
// [R12] undervoltage condition latches the undervoltage flag
// [R13] transmit from serial iface, port pins, or direct register bit
// [R14] nothing transmitted while module enable is clear
// [R15] ready bit set about 50 us after enabling
// [R16] bus held recessive between enable and ready
// [R17] offsets decoded against blocking and non-blocking bases
// [R18] control register honours only 16-bit wide writes; code takes any write with both low byte lanes, 32-bit too
// [R19] fault byte: write one clears, zero leaves unchanged
// [R20] upper mask bits gate lower control bits; slope needs mask 11
// [R21] line state byte shows live receive and transmit levels, one dominant
// [R22] routing registers pick transmit source and receive destinations
// [R23] reserved locations read zero and ignore writes
module lpc_ctrl #(
    parameter int READY_CYCLES = lpc_pkg::READY_CYC,
    parameter int WAKE_CYCLES  = lpc_pkg::WAKE_CYC
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [13:0]         adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    output logic                     ack_o,
    // transceiver side
    input  wire logic                overheat_i,
    input  wire logic                disturb_i,
    input  wire logic                undervolt_i,
    input  wire logic                bus_rx_dominant_i,
    input  wire logic                low_power_i,
    output logic                     bus_tx_dominant_o,
    output lpc_pkg::lpc_slope_t      slope_o,
    output logic                     overheat_o,
    output logic                     irq_o,
    output logic                     wakeup_o,
    // routing to serial iface and port pins (high = recessive, as on txd/rxd)
    input  wire logic                serial_txd_i,
    input  wire logic                port_txd_i,
    output logic                     serial_rxd_o,
    output logic                     port_rxd_o
);
    lpc_pkg::lpc_ctrl_t  ctrl_r;
    lpc_pkg::lpc_fault_t fault_r;
    logic [1:0]          txsrc_r;
    logic [1:0]          rxdst_r;
    logic                wake_r;
    logic                ack_r;
    logic [31:0]         rdat_r;
    logic                ot_blk_r;
    logic                uv_blk_r;
    logic                ot_seen_r;
    logic                irq_r;
    logic                rdy_r;
    logic                rx_prev_r;
    logic                dom_long_r;
    logic                tx_dom_r;

    logic                req;
    logic                wr;
    logic                base_ok;
    logic [7:0]          idx;
    logic                rdy_done;
    logic                wake_done;
    logic                txd_in_high;
    logic                tx_want;
    logic                tx_dom_nxt;
    logic [7:0]          mask;
    logic [7:0]          wval;
    logic                flt_clr;
    logic                wake_clr;

    // address split: bits [13:10] pick base page, [9:2] the index
    assign req     = cyc_i && stb_i && !ack_r;
    assign idx     = adr_i[9:2];
    assign base_ok = ({adr_i[13:10], 8'h00} == lpc_pkg::BASE_BLOCK)
                  || ({adr_i[13:10], 8'h00} == lpc_pkg::BASE_NOBLOCK); // [R17]
    assign wr      = req && we_i && base_ok;
    assign mask    = dat_i[15:8];
    assign wval    = dat_i[7:0];
    assign flt_clr  = wr && idx == lpc_pkg::IDX_FAULT && sel_i[0];
    assign wake_clr = wr && idx == lpc_pkg::IDX_WAKE && sel_i[0] && wval[0];

    // single-cycle answer; unmapped reads return zero, never hang the master
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end
    assign ack_o = ack_r;

    // control register; needs both low byte lanes or the write is dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= lpc_pkg::CTRL_RST[5:0]; // [R01]
        end else if (wr && idx == lpc_pkg::IDX_CTRL && sel_i[1:0] == 2'h3) begin // [R18]
            if (mask[lpc_pkg::CTL_OVERHEAT_IRQ_ENABLE]) begin // [R20]
                ctrl_r.irq_en <= wval[lpc_pkg::CTL_OVERHEAT_IRQ_ENABLE];
            end
            if (mask[lpc_pkg::CTL_TXD]) begin
                ctrl_r.direct <= wval[lpc_pkg::CTL_TXD];
            end
            if (mask[lpc_pkg::CTL_LOWVOLT_SHUTDOWN_ENABLE]) begin
                ctrl_r.lv_shutdown <= wval[lpc_pkg::CTL_LOWVOLT_SHUTDOWN_ENABLE];
            end
            if (mask[lpc_pkg::CTL_EN]) begin
                ctrl_r.enable <= wval[lpc_pkg::CTL_EN];
            end
            if (mask[1:0] == 2'h3) begin // [R20]
                ctrl_r.slope <= lpc_pkg::lpc_slope_t'(wval[1:0]); // [R02]
            end
        end
    end

    // routing registers; only the two low bits exist
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txsrc_r <= lpc_pkg::ROUTE_RST;
            rxdst_r <= lpc_pkg::ROUTE_RST;
        end else if (wr && sel_i[0]) begin
            if (idx == lpc_pkg::IDX_TXSRC) begin
                txsrc_r <= wval[1:0]; // [R22]
            end
            if (idx == lpc_pkg::IDX_RXDST) begin
                rxdst_r <= wval[1:0]; // [R22]
            end
        end
    end

    // fault flags: hardware set wins over a simultaneous write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_r <= '0;
        end else begin
            fault_r.overheat  <= overheat_i
                              || (fault_r.overheat && !(flt_clr && wval[lpc_pkg::FLT_OT])); // [R06] [R19]
            fault_r.disturb   <= disturb_i
                              || (fault_r.disturb && !(flt_clr && wval[lpc_pkg::FLT_HF])); // [R19]
            fault_r.undervolt <= undervolt_i
                              || (fault_r.undervolt && !(flt_clr && wval[lpc_pkg::FLT_UV])); // [R12]
        end
    end

    // interrupt: fires on the rising edge of overheat only, cleared by flag ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ot_seen_r <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            ot_seen_r <= overheat_i;
            if (overheat_i && !ot_seen_r && ctrl_r.irq_en) begin // [R05] [R07]
                irq_r <= 1'b1;
            end else if (!fault_r.overheat || !ctrl_r.irq_en) begin // [R06]
                irq_r <= 1'b0;
            end
        end
    end
    assign irq_o = irq_r;

    // overheat shutdown holds until condition gone and transmit input idles high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ot_blk_r <= 1'b0;
        end else if (overheat_i) begin
            ot_blk_r <= 1'b1; // [R04]
        end else if (txd_in_high) begin
            ot_blk_r <= 1'b0; // [R08]
        end
    end
    assign overheat_o = overheat_i; // [R04]

    // undervoltage block stays until the module is disabled or lowvolt_shutdown_enable cleared
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uv_blk_r <= 1'b0;
        end else if (!ctrl_r.lv_shutdown || !ctrl_r.enable) begin
            uv_blk_r <= 1'b0;
        end else if (undervolt_i) begin
            uv_blk_r <= 1'b1; // [R11]
        end
    end

    // ready delay after enable; lost one clock after enable drops
    lpc_timer #(
        .COUNT (READY_CYCLES)
    ) u_ready (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (ctrl_r.enable),
        .done_o (rdy_done)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdy_r <= 1'b0;
        end else begin
            rdy_r <= rdy_done; // [R15]
        end
    end

    // wake-up filter; a glitch shorter than the filter time restarts the count
    lpc_timer #(
        .COUNT (WAKE_CYCLES)
    ) u_wake (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (low_power_i && bus_rx_dominant_i),
        .done_o (wake_done)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_prev_r  <= 1'b0;
            dom_long_r <= 1'b0;
            wake_r     <= 1'b0;
        end else begin
            rx_prev_r <= bus_rx_dominant_i;
            if (!low_power_i) begin
                dom_long_r <= 1'b0;
            end else if (wake_done) begin
                dom_long_r <= 1'b1;
            end else if (!bus_rx_dominant_i) begin
                dom_long_r <= 1'b0;
            end
            // the receiver keeps running in low power for this detector
            if (low_power_i && dom_long_r && rx_prev_r && !bus_rx_dominant_i) begin
                wake_r <= 1'b1; // [R09] [R10]
            end else if (wake_clr) begin
                wake_r <= 1'b0;
            end
        end
    end
    assign wakeup_o = wake_r;

    // transmit source mux; txd inputs are active-low dominant like uart lines
    assign txd_in_high = (!txsrc_r[lpc_pkg::RT_PORT] || port_txd_i)
                      && (!txsrc_r[lpc_pkg::RT_SERIAL] || serial_txd_i);
    assign tx_want     = ctrl_r.direct
                      || (txsrc_r[lpc_pkg::RT_PORT] && !port_txd_i)
                      || (txsrc_r[lpc_pkg::RT_SERIAL] && !serial_txd_i); // [R13]

    // dominant drive permitted only when enabled, ready, and no fault blocks it
    always_comb begin
        tx_dom_nxt = tx_want;
        if (!ctrl_r.enable) begin
            tx_dom_nxt = 1'b0; // [R14]
        end
        if (!rdy_r) begin
            tx_dom_nxt = 1'b0; // [R16]
        end
        if (low_power_i) begin
            tx_dom_nxt = 1'b0; // [R09]
        end
        if (ot_blk_r || overheat_i) begin
            tx_dom_nxt = 1'b0; // [R04]
        end
        if (uv_blk_r || (ctrl_r.lv_shutdown && undervolt_i)) begin
            tx_dom_nxt = 1'b0; // [R11]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_dom_r <= 1'b0;
        end else begin
            tx_dom_r <= tx_dom_nxt;
        end
    end
    assign bus_tx_dominant_o = tx_dom_r;

    // slope decode: code 11 behaves like normal
    always_comb begin
        unique case (ctrl_r.slope)
            lpc_pkg::SLOPE_SLOW:  slope_o = lpc_pkg::SLOPE_SLOW;
            lpc_pkg::SLOPE_FAST:  slope_o = lpc_pkg::SLOPE_FAST;
            lpc_pkg::SLOPE_NORM2: slope_o = lpc_pkg::SLOPE_NORMAL; // [R03]
            lpc_pkg::SLOPE_NORMAL: slope_o = lpc_pkg::SLOPE_NORMAL;
        endcase
    end

    // receive routing: rxd idles high, low when the bus is dominant and that destination is selected
    assign port_rxd_o   = !(rxdst_r[lpc_pkg::RT_PORT] && bus_rx_dominant_i); // [R22]
    assign serial_rxd_o = !(rxdst_r[lpc_pkg::RT_SERIAL] && bus_rx_dominant_i); // [R22]

    // read mux, registered with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_r <= 32'h0000_0000;
        end else if (req) begin
            rdat_r <= 32'h0000_0000; // [R23]
            if (base_ok && !we_i) begin
                unique case (idx)
                    lpc_pkg::IDX_CTRL: begin
                        rdat_r[lpc_pkg::CTL_OVERHEAT_IRQ_ENABLE] <= ctrl_r.irq_en;
                        rdat_r[lpc_pkg::CTL_TXD]  <= ctrl_r.direct;
                        rdat_r[lpc_pkg::CTL_LOWVOLT_SHUTDOWN_ENABLE] <= ctrl_r.lv_shutdown;
                        rdat_r[lpc_pkg::CTL_EN]   <= ctrl_r.enable;
                        rdat_r[1:0]               <= ctrl_r.slope;
                    end
                    lpc_pkg::IDX_FAULT: begin
                        rdat_r[lpc_pkg::FLT_OT] <= fault_r.overheat;
                        rdat_r[lpc_pkg::FLT_HF] <= fault_r.disturb;
                        rdat_r[lpc_pkg::FLT_UV] <= fault_r.undervolt;
                    end
                    lpc_pkg::IDX_LINE: begin
                        rdat_r[lpc_pkg::LS_RDY] <= rdy_r;
                        rdat_r[lpc_pkg::LS_RX]  <= bus_rx_dominant_i; // [R21]
                        rdat_r[lpc_pkg::LS_TX]  <= tx_dom_r; // [R21]
                    end
                    lpc_pkg::IDX_TXSRC: rdat_r[1:0] <= txsrc_r;
                    lpc_pkg::IDX_RXDST: rdat_r[1:0] <= rxdst_r;
                    lpc_pkg::IDX_WAKE:  rdat_r[0]   <= wake_r;
                    default:            rdat_r      <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign dat_o = rdat_r;

endmodule : lpc_ctrl

//--- lpc_pkg.sv
/*
 * lpc_pkg: shared constants and carrier types for the transceiver control block.
 * assumes a 50 MHz system clock and a classic 32-bit Wishbone register bus.
 */
package lpc_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  IDX_CTRL     = 8'h50;
    localparam logic [7:0]  IDX_FAULT    = 8'h52;
    localparam logic [7:0]  IDX_LINE     = 8'h53;
    localparam logic [7:0]  IDX_TXSRC    = 8'h54;
    localparam logic [7:0]  IDX_RXDST    = 8'h55;
    localparam logic [7:0]  IDX_RSVD_A   = 8'h56;
    localparam logic [7:0]  IDX_RSVD_B   = 8'h57;
    localparam logic [7:0]  IDX_WAKE     = 8'h58;

    // decode bases for the two access flavours
    localparam logic [11:0] BASE_BLOCK   = 12'h200;
    localparam logic [11:0] BASE_NOBLOCK = 12'h300;

    // control field positions
    localparam int          CTL_OVERHEAT_IRQ_ENABLE     = 7;
    localparam int          CTL_TXD      = 4;
    localparam int          CTL_LOWVOLT_SHUTDOWN_ENABLE     = 3;
    localparam int          CTL_EN       = 2;
    localparam int          CTL_MASK_SH  = 8;

    // fault flag positions
    localparam int          FLT_OT       = 7;
    localparam int          FLT_HF       = 5;
    localparam int          FLT_UV       = 3;

    // line state positions
    localparam int          LS_RDY       = 7;
    localparam int          LS_RX        = 1;
    localparam int          LS_TX        = 0;

    // routing positions
    localparam int          RT_PORT      = 1;
    localparam int          RT_SERIAL    = 0;

    // reset values
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [1:0]  ROUTE_RST    = 2'h0;

    // timing
    localparam int          CLK_HZ       = 50_000_000;
    localparam int          READY_US     = 50;
    localparam int          READY_CYC    = (CLK_HZ / 1_000_000) * READY_US;
    localparam int          WAKE_FILT_US = 150;
    localparam int          WAKE_CYC     = (CLK_HZ / 1_000_000) * WAKE_FILT_US;

    typedef enum logic [1:0] {
        SLOPE_NORMAL = 2'h0,
        SLOPE_SLOW   = 2'h1,
        SLOPE_FAST   = 2'h2,
        SLOPE_NORM2  = 2'h3
    } lpc_slope_t;

    typedef struct packed {
        logic       irq_en;
        logic       direct;
        logic       lv_shutdown;
        logic       enable;
        lpc_slope_t slope;
    } lpc_ctrl_t;

    typedef struct packed {
        logic overheat;
        logic disturb;
        logic undervolt;
    } lpc_fault_t;

endpackage : lpc_pkg

//--- lpc_timer.sv
/*
 * lpc_timer: restartable cycle counter that reports when a level has held long enough.
 * assumes run_i is synchronous to clk_i; done_o stays high while run_i stays high.
 */
`timescale 1ns/1ps
module lpc_timer #(
    parameter int COUNT = 2500
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    output logic      done_o
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT);

    logic [W-1:0] cnt_r;

    // count while run is held, saturate at the target, restart when it drops
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_r <= '0;
        end else if (cnt_r != LAST) begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    assign done_o = run_i && (cnt_r == LAST);

endmodule : lpc_timer

//--- lpc_bus_node.sv
/*
 * lpc_bus_node: behavioural model of the other nodes on the shared single-wire bus.
 * assumes the bench commands when another node pulls the wire dominant.
 */
`timescale 1ns/1ps
module lpc_bus_node (
    input  wire logic tx_dominant_i,
    input  wire logic node_dominant_i,
    output logic      bus_dominant_o
);
    // wired bus: any node driving dominant wins, the pull-up gives recessive otherwise
    assign bus_dominant_o = tx_dominant_i | node_dominant_i;
endmodule : lpc_bus_node

//--- lpc_ctrl_sva.sv
/*
 * lpc_ctrl_sva: concurrent checks on the ports of lpc_ctrl.
 * assumes one clock domain, clk_i with synchronous rst_i; bound to lpc_ctrl below.
 */
`timescale 1ns/1ps
module lpc_ctrl_sva (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                cyc_i,
    input wire logic                stb_i,
    input wire logic                ack_o,
    input wire logic                overheat_i,
    input wire logic                low_power_i,
    input wire logic                bus_rx_dominant_i,
    input wire logic                bus_tx_dominant_o,
    input wire lpc_pkg::lpc_slope_t slope_o,
    input wire logic                overheat_o,
    input wire logic                irq_o,
    input wire logic                wakeup_o,
    input wire logic                serial_rxd_o,
    input wire logic                port_rxd_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a bus request that has not been answered yet
    sequence wb_req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    // a condition seen on two edges in a row, so registered outputs have settled
    sequence hot_s;
        overheat_i ##1 overheat_i;
    endsequence

    wb_answer_a: assert property (wb_req_s |=> ack_o)
        else $error("bus request not acknowledged next cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("acknowledge held longer than one cycle");
    heat_follow_a: assert property (overheat_o == overheat_i)
        else $error("overheat indication does not follow the condition");
    heat_block_a: assert property (hot_s |-> !bus_tx_dominant_o)
        else $error("transmitter dominant during overheat");
    sleep_quiet_a: assert property (low_power_i ##1 low_power_i |-> !bus_tx_dominant_o)
        else $error("transmitter dominant in low power");
    slope_code_a: assert property (slope_o != lpc_pkg::SLOPE_NORM2)
        else $error("slope code 11 not folded to normal");
    irq_cause_a: assert property ($rose(irq_o) |-> $past(overheat_i))
        else $error("interrupt raised without overheat");
    no_retrigger_a: assert property (!irq_o && overheat_i && $past(overheat_i) |=> !irq_o)
        else $error("interrupt retriggered by a lasting overheat");
    rx_idle_a: assert property (!bus_rx_dominant_i |-> serial_rxd_o && port_rxd_o)
        else $error("receive output low while bus recessive");
    wake_cause_a: assert property ($rose(wakeup_o) |-> $past(low_power_i))
        else $error("wake-up recorded outside low power");
    reset_quiet_a: assert property (disable iff (1'h0) rst_i |=> !ack_o && !irq_o && !bus_tx_dominant_o)
        else $error("outputs active after reset");
endmodule : lpc_ctrl_sva

bind lpc_ctrl lpc_ctrl_sva u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .overheat_i(overheat_i),
    .low_power_i(low_power_i), .bus_rx_dominant_i(bus_rx_dominant_i), .bus_tx_dominant_o(bus_tx_dominant_o),
    .slope_o(slope_o), .overheat_o(overheat_o), .irq_o(irq_o), .wakeup_o(wakeup_o),
    .serial_rxd_o(serial_rxd_o), .port_rxd_o(port_rxd_o)
);

//--- lpc_ctrl_test.sv
/*
 * lpc_ctrl_test: self-checking bench for lpc_ctrl with a bus-node partner.
 * assumes lpc_pkg, lpc_ctrl, lpc_bus_node and the checker are compiled first.
 */
`timescale 1ns/1ps
module lpc_ctrl_test;
    localparam int RDY = 10;
    localparam int WK  = 20;
    logic                clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, node_dom;
    logic [13:0]         adr_i;
    logic [3:0]          sel_i;
    logic [31:0]         dat_i, dat_o, rd;
    logic                overheat_i, disturb_i, undervolt_i, bus_rx_dominant_i, low_power_i;
    logic                bus_tx_dominant_o, overheat_o, irq_o, wakeup_o;
    logic                serial_txd_i, port_txd_i, serial_rxd_o, port_rxd_o;
    lpc_pkg::lpc_slope_t slope_o;
    int                  mismatches, checked;

    // short counts keep the ready and wake-up filter waits brief
    lpc_ctrl #(.READY_CYCLES(RDY), .WAKE_CYCLES(WK)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .overheat_i(overheat_i),
        .disturb_i(disturb_i), .undervolt_i(undervolt_i), .bus_rx_dominant_i(bus_rx_dominant_i),
        .low_power_i(low_power_i), .bus_tx_dominant_o(bus_tx_dominant_o), .slope_o(slope_o),
        .overheat_o(overheat_o), .irq_o(irq_o), .wakeup_o(wakeup_o), .serial_txd_i(serial_txd_i),
        .port_txd_i(port_txd_i), .serial_rxd_o(serial_rxd_o), .port_rxd_o(port_rxd_o));
    lpc_bus_node u_node (.tx_dominant_i(bus_tx_dominant_o), .node_dominant_i(node_dom),
                         .bus_dominant_o(bus_rx_dominant_i));

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_pin(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t pin state %b expected %b", $time, got, exp);
        end
    endtask : chk_pin
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    // one classic cycle: the request stands until ack is sampled high
    task automatic wb(input logic w, input logic [11:0] base, input logic [7:0] idx, input logic [3:0] sel,
                      input logic [31:0] wd);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i  <= w;
        adr_i <= {base[11:8], idx, 2'h0}; // byte address is four times base plus index
        sel_i <= sel;
        dat_i <= wd;
        // a missing answer is left to the watchdog
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'h1);
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        wb(1'h1, lpc_pkg::BASE_BLOCK, idx, 4'hF, wd);
    endtask : wr
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        wb(1'h0, lpc_pkg::BASE_BLOCK, idx, 4'hF, 32'h0);
        chk_reg(rd, exp);
    endtask : rchk

    task automatic t_regs;
        rchk(lpc_pkg::IDX_CTRL, 32'h0);
        chk_pin(slope_o === lpc_pkg::SLOPE_NORMAL, 1'h1);
        wr(lpc_pkg::IDX_RSVD_A, 32'hFF);
        rchk(lpc_pkg::IDX_RSVD_A, 32'h0);
        rchk(8'h60, 32'h0);
        wr(lpc_pkg::IDX_CTRL, 32'h1010);
        tick(3);
        chk_pin(bus_tx_dominant_o, 1'h0);
        wr(lpc_pkg::IDX_CTRL, 32'h0102);
        chk_pin(slope_o === lpc_pkg::SLOPE_NORMAL, 1'h1);
        wb(1'h1, lpc_pkg::BASE_BLOCK, lpc_pkg::IDX_CTRL, 4'h1, 32'h0302);
        chk_pin(slope_o === lpc_pkg::SLOPE_NORMAL, 1'h1);
        for (int c = 0; c < 4; c++) begin
            wb(1'h1, lpc_pkg::BASE_NOBLOCK, lpc_pkg::IDX_CTRL, 4'hF, 32'h0300 | 32'(c));
            chk_pin(slope_o === 2'(c == 3 ? 0 : c), 1'h1);
            wb(1'h0, lpc_pkg::BASE_NOBLOCK, lpc_pkg::IDX_CTRL, 4'hF, 32'h0);
            chk_reg(rd, 32'h10 | 32'(c));
        end
        $display("test regs done");
    endtask : t_regs

    task automatic t_ready;
        int n;
        n = 0;
        wr(lpc_pkg::IDX_CTRL, 32'h0404);
        while (bus_tx_dominant_o !== 1'h1 && n < 4 * RDY) begin
            @(posedge clk_i);
            n++;
        end
        chk_pin(n >= RDY - 3 && n <= RDY + 3, 1'h1);
        rchk(lpc_pkg::IDX_LINE, 32'h83);
        wr(lpc_pkg::IDX_CTRL, 32'h1000);
        node_dom <= 1'h1;
        tick(2);
        rchk(lpc_pkg::IDX_LINE, 32'h82);
        wr(lpc_pkg::IDX_RXDST, 32'h3);
        chk_pin(serial_rxd_o | port_rxd_o, 1'h0);
        wr(lpc_pkg::IDX_RXDST, 32'h1);
        chk_pin(port_rxd_o & ~serial_rxd_o, 1'h1);
        rchk(lpc_pkg::IDX_RXDST, 32'h1);
        node_dom <= 1'h0;
        tick(2);
        $display("test ready done");
    endtask : t_ready

    task automatic t_heat;
        wr(lpc_pkg::IDX_TXSRC, 32'h1);
        wr(lpc_pkg::IDX_CTRL, 32'h8080);
        serial_txd_i <= 1'h0;
        tick(3);
        chk_pin(bus_tx_dominant_o, 1'h1);
        overheat_i <= 1'h1;
        tick(3);
        chk_pin(overheat_o & irq_o & ~bus_tx_dominant_o, 1'h1);
        wr(lpc_pkg::IDX_FAULT, 32'h0);
        rchk(lpc_pkg::IDX_FAULT, 32'h80);
        overheat_i <= 1'h0;
        tick(2);
        chk_pin(irq_o, 1'h1);
        wr(lpc_pkg::IDX_FAULT, 32'h80);
        rchk(lpc_pkg::IDX_FAULT, 32'h0);
        chk_pin(irq_o | bus_tx_dominant_o, 1'h0);
        serial_txd_i <= 1'h1;
        tick(3);
        serial_txd_i <= 1'h0;
        tick(3);
        chk_pin(bus_tx_dominant_o, 1'h1);
        overheat_i <= 1'h1;
        tick(3);
        chk_pin(irq_o, 1'h1);
        overheat_i <= 1'h0;
        serial_txd_i <= 1'h1;
        tick(3);
        wr(lpc_pkg::IDX_FAULT, 32'h80);
        $display("test heat done");
    endtask : t_heat

    task automatic t_uv;
        serial_txd_i <= 1'h0;
        wr(lpc_pkg::IDX_CTRL, 32'h0808);
        undervolt_i <= 1'h1;
        disturb_i <= 1'h1;
        tick(3);
        undervolt_i <= 1'h0;
        disturb_i <= 1'h0;
        tick(3);
        chk_pin(bus_tx_dominant_o, 1'h0);
        rchk(lpc_pkg::IDX_FAULT, 32'h28);
        wr(lpc_pkg::IDX_FAULT, 32'h28);
        rchk(lpc_pkg::IDX_FAULT, 32'h0);
        wr(lpc_pkg::IDX_CTRL, 32'h0800);
        tick(3);
        chk_pin(bus_tx_dominant_o, 1'h1);
        $display("test undervoltage done");
    endtask : t_uv

    task automatic t_wake;
        low_power_i <= 1'h1;
        tick(3);
        chk_pin(bus_tx_dominant_o, 1'h0);
        serial_txd_i <= 1'h1;
        node_dom <= 1'h1;
        tick(WK / 2);
        chk_pin(serial_rxd_o, 1'h0);
        node_dom <= 1'h0;
        tick(4);
        chk_pin(wakeup_o, 1'h0);
        node_dom <= 1'h1;
        tick(WK + 4);
        node_dom <= 1'h0;
        tick(4);
        chk_pin(wakeup_o, 1'h1);
        rchk(lpc_pkg::IDX_WAKE, 32'h1);
        low_power_i <= 1'h0;
        $display("test wake done");
    endtask : t_wake

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // 50 MHz system clock
    initial begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        finish_test();
    end
    // main sequence; port_txd_i stays recessive since the port source is not exercised
    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {3'h4, 51'h0};
        {overheat_i, disturb_i, undervolt_i, low_power_i, node_dom} = 5'h0;
        {serial_txd_i, port_txd_i} = 2'h3;
        mismatches = 0;
        checked = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_regs();
        t_ready();
        t_heat();
        t_uv();
        t_wake();
        finish_test();
    end
endmodule : lpc_ctrl_test
